/* pkg/pcdc_pkg.sv */
// pcdc_pkg: constants, types and register map of the clock divider control
// assumes one oscillator clock (MCLK_I) feeding every counter below
package pcdc_pkg;

  localparam int unsigned OSC_FREQ_HZ = 20000000;

  // register map (byte address of the control register)
  localparam logic [7:0] PCDC_CTRL_ADDR  = 8'h8f;
  localparam logic [7:0] PCDC_CTRL_RESET = 8'h00;

  // field positions inside the control register
  localparam int unsigned BIT_CORE_X2  = 0;
  localparam int unsigned BIT_TIMER0   = 1;
  localparam int unsigned BIT_TIMER1   = 2;
  localparam int unsigned BIT_TIMER2   = 3;
  localparam int unsigned BIT_SERIAL   = 4;
  localparam int unsigned BIT_CNT_ARR  = 5;
  localparam int unsigned BIT_WATCHDOG = 6;
  localparam int unsigned BIT_BUS_CTRL = 7;
  localparam int unsigned NUM_PERIPH   = 7;

  // serial modes that take their bit clock from the peripheral divider
  localparam logic [1:0] SER_MODE_SYNC  = 2'h0;
  localparam logic [1:0] SER_MODE_FIXED = 2'h2;

  // divider figures in oscillator periods
  localparam int unsigned PER_FAST = 6;
  localparam int unsigned PER_SLOW = 12;

  // reset timing in oscillator periods
  localparam int unsigned RST_MIN_PERIODS = 24;
  localparam int unsigned WDT_PULSE_PERIODS = 96;

  localparam logic [3:0] DIV_FAST_LAST = 4'(PER_FAST - 1);
  localparam logic [3:0] DIV_SLOW_LAST = 4'(PER_SLOW - 1);
  localparam logic [4:0] RST_MIN_LAST  = 5'(RST_MIN_PERIODS - 1);
  localparam logic [6:0] WDT_LAST      = 7'(WDT_PULSE_PERIODS - 1);

  typedef struct packed {
    logic       bus_ctrl_fast_clock_sel;
    logic       watchdog_fast_clock_sel;
    logic       counter_array_fast_clock_sel;
    logic       serial_fast_clock_sel;
    logic       timer_two_fast_clock_sel;
    logic       timer_one_fast_clock_sel;
    logic       timer_zero_fast_clock_sel;
    logic       core_double_speed;
  } pcdc_ctrl_s;

  typedef enum logic [1:0] {
    RST_IDLE  = 2'h0,
    RST_WDT   = 2'h1,
    RST_HOLD  = 2'h2
  } pcdc_rst_e;

  typedef struct packed {
    pcdc_ctrl_s                  ctrl;
    logic                        x2_live;
    logic                        half_ph;
    logic [3:0]                  core_cnt;
    logic [NUM_PERIPH-1:0][3:0]  per_cnt;
    logic [NUM_PERIPH-1:0]       per_en;
    logic                        core_en;
    logic [7:0]                  rdata;
    pcdc_rst_e                   rst_st;
    logic [6:0]                  rst_cnt;
    logic                        rst_drv;
    logic                        rst_int;
  } pcdc_state_s;

endpackage

/* core/pcdc_top.sv */
// pcdc_top: clock speed control register, core and peripheral clock
// enables, reset recognition and watchdog reset pulse
// assumes every input is synchronous to MCLK_I, the oscillator clock
// limitation: idle and power-down clock gating are not handled here
//
// The strobed register port was decided locally.
`timescale 1ns/1ps

// Function
// - bits 7..1 are peripheral speed selects, bit 0 is core double speed
// - peripheral bit clear selects 6 periods per peripheral clock in core double speed
// - peripheral bit set selects 12 periods per peripheral clock
// - serial speed bit affects only serial modes 0 and 2
// - reset clears the whole control register, core in standard speed
// - high level on reset input is the reset condition
// - warm reset comes from the pin or an internal source
// - reset recognition length is the same in both core speeds
// - watchdog expiry drives a 96 oscillator period pulse on reset pin
// - core double speed bit selects 6 instead of 12 periods per cycle
// - peripheral fast only with core double speed set and own bit clear
// - core speed bit change takes effect on divide-by-two rising edge; a warm reset clears core speed at once
module pcdc_top
  import pcdc_pkg::*;
(
  input  wire logic                  MCLK_I,
  input  wire logic                  SYS_RST_I,
  input  wire logic [7:0]            ADDR_I,
  input  wire logic [7:0]            WDATA_I,
  input  wire logic                  WR_I,
  input  wire logic                  RD_I,
  output logic      [7:0]            RDATA_O,
  input  wire logic                  RST_PIN_I,
  input  wire logic                  WDT_EXPIRE_I,
  input  wire logic                  INT_RST_REQ_I,
  input  wire logic [1:0]            SERIAL_MODE_I,
  output logic                       RST_PIN_O,
  output logic                       RST_PIN_OE_O,
  output logic                       CHIP_RST_O,
  output logic                       CORE_CLK_EN_O,
  output logic                       CORE_X2_O,
  output logic      [NUM_PERIPH-1:0] PERIPH_CLK_EN_O
);

  pcdc_state_s s_q;
  pcdc_state_s s_d;

  // fast divider applies only when core is double speed and own bit clear
  function automatic logic [3:0] last_count(input logic x2,
                                            input logic slow_bit);
    last_count = (x2 && !slow_bit) ? DIV_FAST_LAST
                                   : DIV_SLOW_LAST;
  endfunction

  // one decode shared by the write and the read path
  function automatic logic is_ctrl_addr(input logic [7:0] addr);
    is_ctrl_addr = (addr == PCDC_CTRL_ADDR);
  endfunction

  // serial modes 0 and 2 are the only ones clocked from this divider
  function automatic logic serial_on_divider(input logic [1:0] mode);
    serial_on_divider = (mode == SER_MODE_SYNC) ||
                        (mode == SER_MODE_FIXED);
  endfunction

  logic [NUM_PERIPH-1:0] slow_bits;
  logic                  serial_sync_mode;
  logic [3:0]            core_last;

  assign serial_sync_mode = serial_on_divider(SERIAL_MODE_I);
  // the core has no slow bit of its own, only the double speed bit
  assign core_last = last_count(s_q.x2_live, 1'b0);

  always_comb
  begin
    slow_bits = s_q.ctrl[NUM_PERIPH:1];
    // other serial modes keep the standard divider whatever the bit says
    if (!serial_sync_mode)
    begin
      slow_bits[BIT_SERIAL-1] = 1'b1;
    end
  end

  logic rst_cond;
  // pin level or internal source both start a warm reset
  assign rst_cond = RST_PIN_I || INT_RST_REQ_I;

  always_comb
  begin
    s_d = s_q;
    s_d.core_en = 1'b0;
    s_d.per_en = '0;
    s_d.rst_int = 1'b0;

    if (WR_I && is_ctrl_addr(ADDR_I))
    begin
      s_d.ctrl = pcdc_ctrl_s'(WDATA_I);
    end
    if (RD_I && is_ctrl_addr(ADDR_I))
    begin
      s_d.rdata = 8'(s_q.ctrl);
    end
    else
    begin
      // unmapped reads and idle cycles show zero on the read bus
      s_d.rdata = 8'h00;
    end

    // divide-by-two phase; core speed latched only on its rising edge
    s_d.half_ph = ~s_q.half_ph;
    if (!s_q.half_ph)
    begin
      s_d.x2_live = s_q.ctrl.core_double_speed;
    end

    // core: 6 periods in double speed, 12 in standard
    if (s_q.core_cnt >= core_last)
    begin
      s_d.core_cnt = 4'h0;
      s_d.core_en = 1'b1;
    end
    else
    begin
      s_d.core_cnt = s_q.core_cnt + 4'h1;
    end

    // one counter per peripheral, so a change to one peripheral bit never moves another
    for (int i = 0; i < NUM_PERIPH; i++)
    begin
      if (s_q.per_cnt[i] >= last_count(s_q.x2_live, slow_bits[i]))
      begin
        s_d.per_cnt[i] = 4'h0;
        s_d.per_en[i] = 1'b1;
      end
      else
      begin
        s_d.per_cnt[i] = s_q.per_cnt[i] + 4'h1;
      end
    end

    // reset sequencer; counts oscillator periods, speed independent
    unique case (s_q.rst_st)
      RST_IDLE:
      begin
        s_d.rst_cnt = 7'h00;
        // expiry wins: the pulse it drives must not look like a pin reset
        if (WDT_EXPIRE_I)
        begin
          s_d.rst_st = RST_WDT;
          s_d.rst_drv = 1'b1;
        end
        else if (rst_cond)
        begin
          s_d.rst_st = RST_HOLD;
          s_d.rst_cnt = 7'h01;
        end
      end
      RST_WDT:
      begin
        if (s_q.rst_cnt == WDT_LAST)
        begin
          s_d.rst_drv = 1'b0;
          s_d.rst_st = RST_IDLE;
          s_d.rst_cnt = 7'h00;
          s_d.rst_int = 1'b1;
        end
        else
        begin
          s_d.rst_cnt = s_q.rst_cnt + 7'h01;
        end
      end
      RST_HOLD:
      begin
        // shorter pulses are dropped; the far party must hold 24 periods
        if (!rst_cond)
        begin
          s_d.rst_st = RST_IDLE;
          s_d.rst_cnt = 7'h00;
        end
        else if (s_q.rst_cnt[4:0] >= RST_MIN_LAST)
        begin
          // chip reset stays high for as long as the request is held
          s_d.rst_int = 1'b1;
        end
        else
        begin
          s_d.rst_cnt = s_q.rst_cnt + 7'h01;
        end
      end
      default:
      begin
        s_d.rst_st = RST_IDLE;
      end
    endcase

    // register clear lands one cycle after the chip reset is raised
    if (s_q.rst_int)
    begin
      s_d.ctrl = pcdc_ctrl_s'(PCDC_CTRL_RESET);
      s_d.x2_live = 1'b0;
    end
  end

  // cold reset zeroes every field, which is also the register's reset value
  always_ff @(posedge MCLK_I or posedge SYS_RST_I)
  begin
    if (SYS_RST_I)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign RDATA_O         = s_q.rdata;
  // the block only ever drives the reset pin high, so the enable follows it
  assign RST_PIN_O       = s_q.rst_drv;
  assign RST_PIN_OE_O    = s_q.rst_drv;
  assign CHIP_RST_O      = s_q.rst_int;
  assign CORE_CLK_EN_O   = s_q.core_en;
  assign CORE_X2_O       = s_q.x2_live;
  assign PERIPH_CLK_EN_O = s_q.per_en;

endmodule

/* sim/pcdc_top_checker.sv */
// pcdc_top_checker: port assertions for the clock divider control
// assumes it is bound onto pcdc_top, one clock MCLK_I
`timescale 1ns/1ps
module pcdc_top_checker
  import pcdc_pkg::*;
(
  input wire logic       MCLK_I,
  input wire logic       SYS_RST_I,
  input wire logic [7:0] ADDR_I,
  input wire logic [7:0] WDATA_I,
  input wire logic       WR_I,
  input wire logic       RD_I,
  input wire logic [7:0] RDATA_O,
  input wire logic       RST_PIN_I,
  input wire logic       WDT_EXPIRE_I,
  input wire logic       INT_RST_REQ_I,
  input wire logic       RST_PIN_O,
  input wire logic       CHIP_RST_O,
  input wire logic       CORE_CLK_EN_O,
  input wire logic       CORE_X2_O,
  input wire logic [6:0] PERIPH_CLK_EN_O
);
  // run length of the warm reset request, saturating
  logic [5:0] hi_q;
  always_ff @(posedge MCLK_I or posedge SYS_RST_I)
    if (SYS_RST_I)
      hi_q <= 6'h00;
    else if (!(RST_PIN_I || INT_RST_REQ_I))
      hi_q <= 6'h00;
    else if (hi_q != 6'h3f)
      hi_q <= hi_q + 6'h01;

  default clocking @(posedge MCLK_I); endclocking
  default disable iff (SYS_RST_I);

  AST_RD_ZERO: assert property (!(RD_I && ADDR_I == 8'h8f) |=>
    RDATA_O == 8'h00) else $error("read data outside read slot");
  AST_WDT_LEN: assert property ($rose(RST_PIN_O) |->
    ##95 RST_PIN_O ##1 !RST_PIN_O) else $error("pin pulse length");
  AST_WDT_SRC: assert property ($rose(RST_PIN_O) |->
    $past(WDT_EXPIRE_I)) else $error("pin pulse without expiry");
  AST_CHIP_HOLD: assert property (hi_q >= 6'h1a |->
    CHIP_RST_O) else $error("held reset not recognised");
  AST_CHIP_LATE: assert property ($rose(CHIP_RST_O) |->
    hi_q >= 6'h17 || $past(RST_PIN_O)) else $error("reset too early");
  AST_CORE_GAP: assert property (CORE_CLK_EN_O |=>
    !CORE_CLK_EN_O [*5]) else $error("core enable too close");
  AST_T0_SLOW: assert property (PERIPH_CLK_EN_O[0] &&
    !CORE_X2_O |-> ##6 (!PERIPH_CLK_EN_O[0] || CORE_X2_O))
    else $error("timer0 fast");
  AST_X2_APPLY: assert property ((WR_I && ADDR_I == 8'h8f &&
    WDATA_I[0]) ##1 !WR_I [*3] |-> CORE_X2_O) else $error("x2 late");
  AST_X2_PHASE: assert property ($changed(CORE_X2_O) &&
    !CHIP_RST_O |=> $stable(CORE_X2_O)) else $error("x2 off phase");

  cover property (CORE_X2_O && CORE_CLK_EN_O);
  cover property ($fell(RST_PIN_O));
  cover property ($rose(CHIP_RST_O) && !$past(RST_PIN_O));
endmodule

bind pcdc_top pcdc_top_checker pcdc_top_checker_i (.MCLK_I, .SYS_RST_I,
  .ADDR_I, .WDATA_I, .WR_I, .RD_I, .RDATA_O, .RST_PIN_I, .WDT_EXPIRE_I,
  .INT_RST_REQ_I, .RST_PIN_O, .CHIP_RST_O, .CORE_CLK_EN_O, .CORE_X2_O,
  .PERIPH_CLK_EN_O);

/* sim/tb_pcdc_top.sv */
// tb_pcdc_top: directed tests of the clock divider control
// assumes pcdc_pkg, pcdc_top and its checker are compiled first
`timescale 1ns/1ps
module tb_pcdc_top
  import pcdc_pkg::*;
;
  logic       clk = 0;
  logic       rst = 1;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic       wr = 0;
  logic       rd = 0;
  logic [1:0] src = 2'h0;
  logic       wdt = 0;
  logic [1:0] smode = 2'h0;
  logic [7:0] rdata;
  logic       pin_o;
  logic       oe;
  logic       chip;
  logic       x2;
  wire  [7:0] en;
  int         bad_count = 0;
  int         check_count = 0;
  always #25 clk = ~clk;
  pcdc_top pcdc_top_i (.MCLK_I(clk), .SYS_RST_I(rst), .ADDR_I(addr),
    .WDATA_I(wdata), .WR_I(wr), .RD_I(rd), .RDATA_O(rdata),
    .RST_PIN_I(src[0]), .WDT_EXPIRE_I(wdt), .INT_RST_REQ_I(src[1]),
    .SERIAL_MODE_I(smode), .RST_PIN_O(pin_o), .RST_PIN_OE_O(oe),
    .CHIP_RST_O(chip), .CORE_CLK_EN_O(en[0]), .CORE_X2_O(x2),
    .PERIPH_CLK_EN_O(en[7:1]));
  task chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp)
    begin
      bad_count++;
      $display("BAD %0t value %h want %h", $time, got, exp);
    end
  endtask
  task chkn(input int got, input int exp);
    check_count++;
    if (got != exp)
    begin
      bad_count++;
      $display("BAD %0t count %0d want %0d", $time, got, exp);
    end
  endtask
  task wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task rd_reg(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(rdata, exp);
  endtask
  // gap between two enable pulses; the first gap after a change is skipped
  task setp(input logic [7:0] c, input logic [1:0] m, input int b,
            input int exp);
    int n;
    @(posedge clk);
    smode <= m;
    wr_reg(PCDC_CTRL_ADDR, c);
    repeat (2)
    begin
      n = 0;
      do begin @(posedge clk); #1; n++; end while (en[b] !== 1'b1 && n < 40);
    end
    chkn(n, exp);
  endtask
  task t_reg;
    rd_reg(PCDC_CTRL_ADDR, PCDC_CTRL_RESET);
    wr_reg(PCDC_CTRL_ADDR, 8'ha5);
    rd_reg(PCDC_CTRL_ADDR, 8'ha5);
    wr_reg(8'h80, 8'hff);
    rd_reg(8'h80, 8'h00);
    rd_reg(PCDC_CTRL_ADDR, 8'ha5);
    $display("test reg done");
  endtask
  task t_speed;
    for (int b = 0; b < 8; b++)
    begin
      setp(8'h01, 2'h0, b, PER_FAST);
      setp(8'h01 | (8'h01 << b), 2'h0, b,
           b == 0 ? PER_FAST : PER_SLOW);
      setp(8'h00, 2'h0, b, PER_SLOW);
    end
    for (int m = 0; m < 4; m++)
      setp(8'h01, m[1:0], 4, m[0] ? PER_SLOW : PER_FAST);
    $display("test speed done");
  endtask
  task t_warm(input int s, input logic [7:0] c);
    wr_reg(PCDC_CTRL_ADDR, c);
    @(posedge clk);
    src[s] <= 1'b1;
    repeat (RST_MIN_PERIODS - 4) @(posedge clk);
    #1 chk({7'h0, chip}, 8'h00);
    repeat (6) @(posedge clk);
    #1 chk({7'h0, chip}, 8'h01);
    @(posedge clk);
    src[s] <= 1'b0;
    repeat (4) @(posedge clk);
    rd_reg(PCDC_CTRL_ADDR, PCDC_CTRL_RESET);
    chk({7'h0, x2}, 8'h00);
    $display("test warm reset done");
  endtask
  // expiry held three edges: the two later ones fall inside the pulse
  task t_wdt;
    int n;
    wr_reg(PCDC_CTRL_ADDR, 8'hff);
    @(posedge clk);
    wdt <= 1'b1;
    repeat (3) @(posedge clk);
    wdt <= 1'b0;
    n = 0;
    #1;
    chk({6'h0, oe, pin_o}, 8'h03);
    while (pin_o === 1'b1 && n < 200) begin @(posedge clk); #1; n++; end
    chkn(n, WDT_PULSE_PERIODS - 2);
    chk({7'h0, oe}, 8'h00);
    chk({7'h0, chip}, 8'h01);
    rd_reg(PCDC_CTRL_ADDR, PCDC_CTRL_RESET);
    $display("test watchdog done");
  endtask
  task results;
    $display("checks %0d bad %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial
  begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    t_reg;
    t_speed;
    t_warm(0, 8'h5b);
    t_warm(1, 8'h5a);
    t_wdt;
    results;
  end
  initial
  begin
    repeat (6000) @(posedge clk);
    bad_count++;
    results;
  end
endmodule
